// [rtl/gpt_pkg.sv]
/*
  Shared constants and types of the four-timer block: prescale figures,
  clock source and mode codes, flag positions and the configuration carriers.
  Assumes a single system clock domain; every user is written gpt_pkg::name.
*/
// Function
// - Timers 0/1 clock: system, /12, /4, /48.
// - Timers 0/1 also: external oscillator /8, pin edges.
// - Timers 0/1 modes: 8-bit reload, 13-bit, 16-bit.
// - Four modes; split mode on timer 0 only.
// - Timer 0 split: two separate 8-bit counters.
// - Timers 2/3 clock: system, /12, oscillator /8.
// - Timers 2/3: 16-bit reload on overflow.
// - Timers 2/3 split: two reloading 8-bit halves.
// - Timer 2 captures on comparator or time-of-day.
// - Timer 3 captures on time-of-day or oscillator /8.
// - All timers: interval, periodic requests; pin event count on timers 0/1 only.
package gpt_pkg;

  // Prescale divisors and the last state of the shared prescaler.
  localparam int DIV_FAST = 4;
  localparam int DIV_MID = 12;
  localparam int DIV_SLOW = 48;
  localparam logic [5:0] PRESCALE_LAST = 6'(DIV_SLOW - 1);
  localparam logic [5:0] MID_LAST = 6'(DIV_MID - 1);
  localparam logic [1:0] FAST_LAST = 2'(DIV_FAST - 1);

  // The external oscillator is divided by eight before use.
  localparam logic [2:0] EXT_LAST = 3'h7;

  // Reset value of every counter and capture register.
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Positions in the flag vector.
  localparam int FLAG_COUNT = 7;
  localparam int FLAG_T0 = 0;
  localparam int FLAG_T0_HIGH = 4;
  localparam int FLAG_T2_LOW = 5;

  // Count clock choices of timers 0 and 1.
  typedef enum logic [2:0] {
    SRC_SYSTEM = 3'h0, SRC_DIV12 = 3'h1, SRC_DIV4 = 3'h2,
    SRC_DIV48 = 3'h3, SRC_EXT8 = 3'h4, SRC_PIN = 3'h5
  } classic_src_type;

  // Operating modes of timers 0 and 1.
  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0, MODE_16BIT = 2'h1, MODE_AUTO8 = 2'h2, MODE_SPLIT = 2'h3
  } classic_mode_type;

  // Count clock choices of timers 2 and 3.
  typedef enum logic [1:0] {
    RSRC_SYSTEM = 2'h0, RSRC_DIV12 = 2'h1, RSRC_EXT8 = 2'h2
  } reload_src_type;

  // Configuration of one of timers 0 and 1; load is a one-cycle strobe.
  typedef struct packed {
    logic run;
    logic run_high;
    classic_src_type src;
    classic_mode_type mode;
    logic load;
    logic [15:0] load_value;
  } classic_cfg_type;

  // Configuration of one of timers 2 and 3.
  typedef struct packed {
    logic run;
    reload_src_type src;
    logic split;
    logic load;
    logic [15:0] load_value;
    logic [15:0] reload;
    logic capture_enable;
    logic capture_alt;
  } reload_cfg_type;

endpackage

// [rtl/timer_set.sv]
/*
  Four 16-bit counter/timers: two classic timers with four modes and two
  auto-reload timers with capture. Assumes all inputs are synchronous to
  mclk and that configuration strobes are single-cycle pulses.
*/
`timescale 1ns/1ps
module timer_set (
  input wire logic mclk,
  input wire logic resetn,
  input wire gpt_pkg::classic_cfg_type [1:0] classic_cfg,
  input wire gpt_pkg::reload_cfg_type [1:0] reload_cfg,
  input wire logic [1:0] event_pin,
  input wire logic external_oscillator_clock,
  input wire logic comparator_event,
  input wire logic time_of_day_event,
  input wire logic [6:0] flag_clear,
  input wire logic [6:0] irq_enable,
  output logic [3:0][15:0] count,
  output logic [1:0][15:0] capture,
  output logic [6:0] flag,
  output logic [6:0] irq
);

  // Shared prescaler and previous input levels for edge detection.
  logic [5:0] pre;
  logic [5:0] next_pre;
  logic [2:0] ext_cnt;
  logic [2:0] next_ext_cnt;
  logic ext_prev;
  logic [1:0] pin_prev;
  logic cmp_prev;
  logic tod_prev;

  // Prescaled ticks; each is high for one cycle per period.
  logic tick4;
  logic tick12;
  logic tick48;
  logic ext_rise;
  logic ext8;
  logic [1:0] pin_fall;
  logic cmp_rise;
  logic tod_rise;
  logic [3:0] tick; // Selected count tick per timer.
  logic [1:0] cap_event; // Selected capture event per reload timer.

  // Next values of the timer state.
  logic [3:0][15:0] next_count;
  logic [1:0][15:0] next_capture;
  logic [6:0] next_flag;

  // One counter serves all three divisors, so their ticks stay aligned.
  always_comb begin
    next_pre = (pre == gpt_pkg::PRESCALE_LAST) ? 6'h00 : pre + 6'h01;
    next_ext_cnt = ext_rise ? ext_cnt + 3'h1 : ext_cnt;
  end

  assign tick4 = (pre[1:0] == gpt_pkg::FAST_LAST);
  assign tick12 = ((pre % 6'(gpt_pkg::DIV_MID)) == gpt_pkg::MID_LAST);
  assign tick48 = (pre == gpt_pkg::PRESCALE_LAST);
  assign ext_rise = external_oscillator_clock & ~ext_prev;
  assign ext8 = ext_rise & (ext_cnt == gpt_pkg::EXT_LAST);
  // Falling edges count as external events, as classic counters do.
  assign pin_fall = pin_prev & ~event_pin;
  assign cmp_rise = comparator_event & ~cmp_prev;
  assign tod_rise = time_of_day_event & ~tod_prev;

  // Prescaler and edge history registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre <= 6'h00;
      ext_cnt <= 3'h0;
      ext_prev <= 1'b0;
      pin_prev <= 2'h0;
      cmp_prev <= 1'b0;
      tod_prev <= 1'b0;
    end else begin
      pre <= next_pre;
      ext_cnt <= next_ext_cnt;
      ext_prev <= external_oscillator_clock;
      pin_prev <= event_pin;
      cmp_prev <= comparator_event;
      tod_prev <= time_of_day_event;
    end
  end

  // Clock source and capture source selection.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      case (classic_cfg[i].src)
        gpt_pkg::SRC_SYSTEM: tick[i] = 1'b1;
        gpt_pkg::SRC_DIV12: tick[i] = tick12;
        gpt_pkg::SRC_DIV4: tick[i] = tick4;
        gpt_pkg::SRC_DIV48: tick[i] = tick48;
        gpt_pkg::SRC_EXT8: tick[i] = ext8;
        gpt_pkg::SRC_PIN: tick[i] = pin_fall[i];
        default: tick[i] = 1'b0;
      endcase
      case (reload_cfg[i].src)
        gpt_pkg::RSRC_SYSTEM: tick[i + 2] = 1'b1;
        gpt_pkg::RSRC_DIV12: tick[i + 2] = tick12;
        gpt_pkg::RSRC_EXT8: tick[i + 2] = ext8;
        default: tick[i + 2] = 1'b0;
      endcase
    end
    cap_event[0] = reload_cfg[0].capture_alt ? tod_rise : cmp_rise;
    cap_event[1] = reload_cfg[1].capture_alt ? ext8 : tod_rise;
  end

  // Counting, reloading, capture and flag setting. Flags are cleared first and
  // set afterwards, so an overflow in the clearing cycle is kept. A load strobe
  // wins over a tick in the same cycle.
  always_comb begin
    next_count = count;
    next_capture = capture;
    next_flag = flag & ~flag_clear;
    for (int i = 0; i < 2; i++) begin
      if (classic_cfg[i].load) begin
        next_count[i] = classic_cfg[i].load_value;
      end else if (classic_cfg[i].run && tick[i]) begin
        case (classic_cfg[i].mode)
          gpt_pkg::MODE_13BIT: begin
            // Upper three bits stay zero; 13 bits wrap at 0x1fff.
            next_count[i] = {3'h0, count[i][12:0] + 13'h0001};
            if (count[i][12:0] == 13'h1fff) begin
              next_flag[i] = 1'b1;
            end
          end
          gpt_pkg::MODE_16BIT: begin
            next_count[i] = count[i] + 16'h0001;
            if (count[i] == 16'hffff) begin
              next_flag[i] = 1'b1;
            end
          end
          gpt_pkg::MODE_AUTO8: begin
            if (count[i][7:0] == 8'hff) begin
              next_count[i][7:0] = count[i][15:8];
              next_flag[i] = 1'b1;
            end else begin
              next_count[i][7:0] = count[i][7:0] + 8'h01;
            end
          end
          gpt_pkg::MODE_SPLIT: begin
            // Timer 1 has no split mode and simply holds here.
            if (i == 0) begin
              next_count[0][7:0] = count[0][7:0] + 8'h01;
              if (count[0][7:0] == 8'hff) begin
                next_flag[gpt_pkg::FLAG_T0] = 1'b1;
              end
            end
          end
          default: next_count[i] = count[i];
        endcase
      end
    end
    // Timer 0 high half runs on its own enable when split.
    if (!classic_cfg[0].load && classic_cfg[0].mode == gpt_pkg::MODE_SPLIT &&
        classic_cfg[0].run_high && tick[0]) begin
      next_count[0][15:8] = count[0][15:8] + 8'h01;
      if (count[0][15:8] == 8'hff) begin
        next_flag[gpt_pkg::FLAG_T0_HIGH] = 1'b1;
      end
    end
    for (int j = 0; j < 2; j++) begin
      next_count[j + 2] = count[j + 2];
      if (reload_cfg[j].load) begin
        next_count[j + 2] = reload_cfg[j].load_value;
      end else if (reload_cfg[j].run && tick[j + 2]) begin
        if (reload_cfg[j].split) begin
          next_count[j + 2][7:0] = (count[j + 2][7:0] == 8'hff) ?
            reload_cfg[j].reload[7:0] : count[j + 2][7:0] + 8'h01;
          next_count[j + 2][15:8] = (count[j + 2][15:8] == 8'hff) ?
            reload_cfg[j].reload[15:8] : count[j + 2][15:8] + 8'h01;
          if (count[j + 2][7:0] == 8'hff) begin
            next_flag[gpt_pkg::FLAG_T2_LOW + j] = 1'b1;
          end
          if (count[j + 2][15:8] == 8'hff) begin
            next_flag[j + 2] = 1'b1;
          end
        end else if (count[j + 2] == 16'hffff) begin
          next_count[j + 2] = reload_cfg[j].reload;
          next_flag[j + 2] = 1'b1;
        end else begin
          next_count[j + 2] = count[j + 2] + 16'h0001;
        end
      end
      // Capture samples the count before this cycle's increment.
      if (reload_cfg[j].capture_enable && cap_event[j]) begin
        next_capture[j] = count[j + 2];
      end
    end
  end

  // Timer state registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= {4{gpt_pkg::COUNT_RESET}};
      capture <= {2{gpt_pkg::COUNT_RESET}};
      flag <= 7'h00;
    end else begin
      count <= next_count;
      capture <= next_capture;
      flag <= next_flag;
    end
  end

  // Requests follow the sticky flags through their enables.
  assign irq = flag & irq_enable;

  // The three prescaled ticks recur at exactly their divisors.
  div4_period_a: assert property (@(posedge mclk) disable iff (!resetn)
    tick4 |=> !tick4 [*3] ##1 tick4) else $error("divide-by-4 tick period wrong");
  div12_period_a: assert property (@(posedge mclk) disable iff (!resetn)
    tick12 |-> ##12 tick12) else $error("divide-by-12 tick period wrong");
  div48_period_a: assert property (@(posedge mclk) disable iff (!resetn)
    tick48 |=> !tick48 [*8] ##40 tick48) else $error("divide-by-48 tick period wrong");
  ext_divide_a: assert property (@(posedge mclk) disable iff (!resetn)
    ext8 |=> ext_cnt == 3'h0) else $error("oscillator divider did not wrap");

  // Classic timer wraps and reloads.
  wrap16_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    classic_cfg[0].run && !classic_cfg[0].load && tick[0] &&
    classic_cfg[0].mode == gpt_pkg::MODE_16BIT && count[0] == 16'hffff
    |=> count[0] == 16'h0000 && flag[0]) else $error("16-bit wrap wrong");
  wrap13_count_a: assert property (@(posedge mclk) disable iff (!resetn)
    classic_cfg[1].run && !classic_cfg[1].load && tick[1] &&
    classic_cfg[1].mode == gpt_pkg::MODE_13BIT && count[1][12:0] == 13'h1fff
    |=> count[1] == 16'h0000 && flag[1]) else $error("13-bit wrap wrong");
  auto8_reload_a: assert property (@(posedge mclk) disable iff (!resetn)
    classic_cfg[1].run && !classic_cfg[1].load && tick[1] &&
    classic_cfg[1].mode == gpt_pkg::MODE_AUTO8 && count[1][7:0] == 8'hff
    |=> count[1][7:0] == $past(count[1][15:8])) else $error("8-bit reload wrong");
  split_high_a: assert property (@(posedge mclk) disable iff (!resetn)
    classic_cfg[0].mode == gpt_pkg::MODE_SPLIT && classic_cfg[0].run_high &&
    !classic_cfg[0].load && tick[0] && count[0][15:8] == 8'hff
    |=> flag[gpt_pkg::FLAG_T0_HIGH]) else $error("split high overflow lost");
  t1_split_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    classic_cfg[1].mode == gpt_pkg::MODE_SPLIT && !classic_cfg[1].load
    |=> count[1] == $past(count[1])) else $error("timer 1 moved in split mode");

  // Reload timers, capture and flags.
  reload16_a: assert property (@(posedge mclk) disable iff (!resetn)
    reload_cfg[0].run && !reload_cfg[0].load && !reload_cfg[0].split &&
    tick[2] && count[2] == 16'hffff
    |=> count[2] == $past(reload_cfg[0].reload) && flag[2]) else $error("reload wrong");
  capture_take_a: assert property (@(posedge mclk) disable iff (!resetn)
    reload_cfg[0].capture_enable && cap_event[0]
    |=> capture[0] == $past(count[2])) else $error("capture value wrong");
  flag_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
    flag[3] && !flag_clear[3] |=> flag[3]) else $error("flag dropped without clear");

endmodule

// [bench/tb_timer_set.sv]
/*
  Self-checking bench of the four-timer block: drives every control port
  and compares counts, captures, flags and requests with expected values.
  Assumes inputs are sampled on the rising edge of mclk.
*/
`timescale 1ns/1ps
module tb_timer_set;
  logic mclk = 1'b0; // System clock, 4 ns period.
  logic resetn = 1'b0; // Active-low reset.
  gpt_pkg::classic_cfg_type [1:0] cc = '0; // Timers 0 and 1.
  gpt_pkg::reload_cfg_type [1:0] rc = '0; // Timers 2 and 3.
  logic [1:0] event_pin = 2'h3; // Idle high, so a low pulse is one event.
  logic external_oscillator_clock = 1'b0; // Slow oscillator driven by hand.
  logic comparator_event = 1'b0; // Capture source of timer 2.
  logic time_of_day_event = 1'b0; // Capture source of timers 2 and 3.
  logic [6:0] flag_clear = 7'h00; // Clear pulses.
  logic [6:0] irq_enable = 7'h00; // Request enables.
  logic [3:0][15:0] count;
  logic [1:0][15:0] capture;
  logic [6:0] flag;
  logic [6:0] irq;
  int n_errors = 0; // Mismatches seen.
  int checks = 0; // Comparisons made.
  int i; // Loop index.
  int div_of[4] = '{1, gpt_pkg::DIV_MID, gpt_pkg::DIV_FAST, gpt_pkg::DIV_SLOW}; // Per source.

  timer_set timer_set_i (.mclk(mclk), .resetn(resetn), .classic_cfg(cc), .reload_cfg(rc),
    .event_pin(event_pin), .external_oscillator_clock(external_oscillator_clock),
    .comparator_event(comparator_event), .time_of_day_event(time_of_day_event),
    .flag_clear(flag_clear), .irq_enable(irq_enable), .count(count), .capture(capture),
    .flag(flag), .irq(irq));

  // The clock toggles every half period.
  always #2 mclk = ~mclk;

  // Waits n edges, then steps off the edge so drives never race sampling.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Compares one value with case equality so an unknown never matches.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Loads a classic timer with a one-cycle strobe.
  task automatic load_c(input int t, input logic [15:0] v);
    cc[t].load_value = v;
    cc[t].load = 1'b1;
    cyc(1);
    cc[t].load = 1'b0;
  endtask

  // Loads a reload timer with a one-cycle strobe.
  task automatic load_r(input int t, input logic [15:0] v);
    rc[t].load_value = v;
    rc[t].load = 1'b1;
    cyc(1);
    rc[t].load = 1'b0;
  endtask

  // Clears every sticky flag.
  task automatic clear_flags();
    flag_clear = 7'h7f;
    cyc(1);
    flag_clear = 7'h00;
  endtask

  // One rising edge of the oscillator, held high one cycle and low one cycle for the sampler.
  task automatic rise();
    external_oscillator_clock = 1'b1;
    cyc(1);
    external_oscillator_clock = 1'b0;
    cyc(1);
  endtask

  // Raises one capture event: 0 comparator, 3 oscillator, else time of day.
  task automatic fire(input int k);
    if (k == 0) comparator_event = 1'b1;
    else if (k == 3) repeat (8) rise();
    else time_of_day_event = 1'b1;
    cyc(2);
    comparator_event = 1'b0;
    time_of_day_event = 1'b0;
    cyc(2);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short; the tests need a few hundred cycles at most.
  initial begin
    #40000;
    n_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    cyc(5);
    resetn = 1'b1;
    for (i = 0; i < 4; i++) chk(count[i], 16'h0000, "reset count");
    chk({capture[1] | capture[0]}, 16'h0000, "reset capture");
    chk({2'h0, flag, irq}, 16'h0000, "reset flags");
    // A window of 48 cycles holds exactly 48/div ticks whatever the phase.
    cc[0].mode = gpt_pkg::MODE_16BIT;
    for (i = 0; i < 4; i++) begin
      cc[0].src = gpt_pkg::classic_src_type'(i);
      load_c(0, 16'h0000);
      cc[0].run = 1'b1;
      cyc(48);
      cc[0].run = 1'b0;
      chk(count[0], 16'(48 / div_of[i]), "classic prescale");
    end
    for (i = 0; i < 2; i++) begin
      rc[0].src = gpt_pkg::reload_src_type'(i);
      load_r(0, 16'h0000);
      rc[0].run = 1'b1;
      cyc(48);
      rc[0].run = 1'b0;
      chk(count[2], 16'(48 / div_of[i]), "reload prescale");
    end
    // Sixteen oscillator rises give exactly two divided ticks.
    cc[0].src = gpt_pkg::SRC_EXT8;
    rc[0].src = gpt_pkg::RSRC_EXT8;
    load_c(0, 16'h0000);
    load_r(0, 16'h0000);
    cc[0].run = 1'b1;
    rc[0].run = 1'b1;
    repeat (16) rise();
    cc[0].run = 1'b0;
    rc[0].run = 1'b0;
    chk(count[0], 16'h0002, "classic oscillator ticks");
    chk(count[2], 16'h0002, "reload oscillator ticks");
    // Three falling edges at each pin are three events for each classic timer.
    cc[1].mode = gpt_pkg::MODE_16BIT;
    cc[0].src = gpt_pkg::SRC_PIN;
    cc[1].src = gpt_pkg::SRC_PIN;
    load_c(0, 16'h0000);
    load_c(1, 16'h0000);
    cc[0].run = 1'b1;
    cc[1].run = 1'b1;
    repeat (3) begin
      event_pin = 2'h0;
      cyc(1);
      event_pin = 2'h3;
      cyc(1);
    end
    cyc(2);
    cc[0].run = 1'b0;
    cc[1].run = 1'b0;
    chk(count[0], 16'h0003, "pin events timer 0");
    chk(count[1], 16'h0003, "pin events");
    // Overflow sets a sticky flag; the request follows the enable.
    clear_flags();
    irq_enable = 7'h01;
    cc[0].src = gpt_pkg::SRC_SYSTEM;
    load_c(0, 16'hffff);
    cc[0].run = 1'b1;
    cyc(1);
    cc[0].run = 1'b0;
    cyc(3);
    chk(count[0], 16'h0000, "16-bit wrap");
    chk({flag, irq}, 16'h0081, "flag and request");
    irq_enable = 7'h00;
    cyc(1);
    chk({9'h0, irq}, 16'h0000, "masked request");
    clear_flags();
    chk({9'h0, flag}, 16'h0000, "flag cleared");
    // Timer 1 in 13-bit and then 8-bit auto-reload mode.
    cc[1].src = gpt_pkg::SRC_SYSTEM;
    cc[1].mode = gpt_pkg::MODE_13BIT;
    load_c(1, 16'h1fff);
    cc[1].run = 1'b1;
    cyc(1);
    cc[1].mode = gpt_pkg::MODE_AUTO8;
    cc[1].run = 1'b0;
    chk({count[1][15:7], flag}, 16'h0002, "13-bit wrap");
    load_c(1, 16'h05fe);
    cc[1].run = 1'b1;
    cyc(2);
    cc[1].run = 1'b0;
    chk(count[1], 16'h0505, "8-bit reload");
    // Split timer 0: halves run on separate enables; timer 1 split holds.
    clear_flags();
    cc[0].mode = gpt_pkg::MODE_SPLIT;
    load_c(0, 16'h10ff);
    cc[0].run = 1'b1;
    cc[1].mode = gpt_pkg::MODE_SPLIT;
    cc[1].run = 1'b1;
    cyc(1);
    cc[0].run = 1'b0;
    chk({count[0][15:8], 1'b0, flag}, 16'h1001, "split low wrap");
    cc[0].run_high = 1'b1;
    cyc(2);
    cc[0].run_high = 1'b0;
    cc[1].run = 1'b0;
    chk(count[0], 16'h1200, "split high count");
    chk(count[1], 16'h0505, "timer 1 split holds");
    // The high half wraps into its own flag, and the set wins over a clear.
    load_c(0, 16'hff00);
    cc[0].run_high = 1'b1;
    flag_clear = 7'h10;
    cyc(1);
    cc[0].run_high = 1'b0;
    flag_clear = 7'h00;
    chk({count[0][15:8], 1'b0, flag}, 16'h0011, "split high wrap");
    // Timer 2 reloads 16 bits; timer 3 split reloads each byte.
    clear_flags();
    rc[0].src = gpt_pkg::RSRC_SYSTEM;
    rc[0].reload = 16'h1234;
    rc[1].split = 1'b1;
    rc[1].reload = 16'ha5c3;
    load_r(0, 16'hffff);
    load_r(1, 16'hffff);
    rc[0].run = 1'b1;
    rc[1].run = 1'b1;
    cyc(1);
    rc[0].run = 1'b0;
    rc[1].run = 1'b0;
    chk(count[2], 16'h1234, "16-bit reload");
    chk({count[3][15:7], flag}, 16'ha5cc, "split reload and flags");
    clear_flags();
    load_r(1, 16'h00ff);
    rc[1].run = 1'b1;
    cyc(1);
    rc[1].run = 1'b0;
    chk({count[3][15:7], flag}, 16'h01c0, "split low only");
    // Each capture source in turn, with the timer held at a known value.
    for (i = 0; i < 4; i++) begin
      load_r(i / 2, 16'h4000 + 16'(i));
      rc[i / 2].capture_alt = i[0];
      rc[i / 2].capture_enable = 1'b1;
      fire(i);
      rc[i / 2].capture_enable = 1'b0;
      chk(capture[i / 2], 16'h4000 + 16'(i), "capture source");
    end
    // Timer 2 set to the time-of-day source ignores the comparator.
    load_r(0, 16'h7777);
    rc[0].capture_enable = 1'b1;
    fire(0);
    chk(capture[0], 16'h4001, "unselected source");
    end_of_test();
  end
endmodule
